//--- verilog/csas_seq.sv
`timescale 1ns/1ns
module csas_seq #(
    parameter int LINES = 16
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Trigger sources
    input wire logic [LINES-1:0] trig_lines,
    input wire logic timer_arm,
    input wire logic channel_two_arm_source,
    input wire logic signed [15:0] ext_arm_mv,
    // Measurement logic
    input wire logic op_done,
    output logic armed,
    output logic op_start,
    output logic measuring,
    output logic external_arm_source
);
    initial begin
        if (LINES < 1 || LINES > 16) $error("csas_seq: bad LINES");
    end

    // ************************************************************
    // Registers
    // ************************************************************
    logic [4:0] source_q;
    logic [15:0] delay_q;
    logic [15:0] arm_event_count_q;
    logic [15:0] level_q;
    logic slope_neg_q;
    logic mode_once_q;
    logic [15:0] array_q;
    logic ack_q;
    logic [31:0] dat_q;
    logic wr;
    logic rd;
    logic [31:0] wdat;
    logic cmd_init;
    logic cmd_abort;
    logic software_arm_now;
    logic cmd_bus;

    // ************************************************************
    // Wishbone decode
    // ************************************************************
    assign wr = wb_cyc_i && wb_stb_i && wb_we_i && ack_q; // Lands at the ack edge
    assign rd = wb_cyc_i && wb_stb_i && !wb_we_i && !ack_q;
    assign wdat = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}},
                   {8{wb_sel_i[0]}}} & wb_dat_i;
    assign cmd_init = wr && wb_adr_i == csas_pkg::ADDR_CMD && wdat[csas_pkg::CMD_INIT_BIT];
    assign cmd_abort = wr && wb_adr_i == csas_pkg::ADDR_CMD && wdat[csas_pkg::CMD_ABORT_BIT];
    assign software_arm_now = wr && wb_adr_i == csas_pkg::ADDR_CMD
                              && wdat[csas_pkg::CMD_ARM_NOW_BIT];
    assign cmd_bus = wr && wb_adr_i == csas_pkg::ADDR_CMD && wdat[csas_pkg::CMD_BUS_TRIG_BIT];

    // One-cycle ack per request
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= wb_cyc_i && wb_stb_i && !ack_q;
        end
    end
    assign wb_ack_o = ack_q;

    // Source, level, slope, mode and array size
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            source_q <= csas_pkg::RST_SOURCE;
            level_q <= csas_pkg::RST_LEVEL_MV;
            slope_neg_q <= csas_pkg::RST_SLOPE_NEG;
            mode_once_q <= csas_pkg::RST_MODE_ONCE;
            array_q <= csas_pkg::RST_ARRAY;
        end else if (wr) begin
            case (wb_adr_i)
                csas_pkg::ADDR_SOURCE: begin
                    source_q <= wdat[4:0];
                end
                csas_pkg::ADDR_LEVEL: begin
                    level_q <= wdat[15:0];
                end
                csas_pkg::ADDR_CTRL: begin
                    slope_neg_q <= wdat[csas_pkg::CTRL_SLOPE_NEG_BIT];
                    mode_once_q <= wdat[csas_pkg::CTRL_MODE_ONCE_BIT];
                end
                csas_pkg::ADDR_ARRAY: begin
                    array_q <= (wdat[15:0] == 16'h0000) ? 16'h0001 : wdat[15:0];
                end
                default: begin
                end
            endcase
        end
    end

    // Delay and event count, each write zeroing the other
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            delay_q <= csas_pkg::RST_DELAY;
            arm_event_count_q <= csas_pkg::RST_ARM_EVENT_COUNT;
        end else if (wr && wb_adr_i == csas_pkg::ADDR_DELAY) begin
            delay_q <= wdat[15:0];
            arm_event_count_q <= 16'h0000;
        end else if (wr && wb_adr_i == csas_pkg::ADDR_ARM_EVENT_COUNT) begin
            arm_event_count_q <= wdat[15:0];
            delay_q <= 16'h0000;
        end
    end

    // ************************************************************
    // Source selection
    // ************************************************************
    logic ext_fire;
    logic src_fire;
    logic src_fixed;
    logic [4:0] line_idx;

    csas_edge_cmp u_cmp (
        .ref_clk(ref_clk),
        .srst(srst),
        .sample_mv(ext_arm_mv),
        .level_mv(level_q),
        .slope_neg(slope_neg_q),
        .fire(ext_fire)
    );

    assign line_idx = source_q - csas_pkg::SRC_LINE_BASE;

    // Selected source pulse
    always_comb begin
        src_fire = 1'b0;
        case (source_q)
            csas_pkg::SRC_HOLD: src_fire = 1'b0;
            csas_pkg::SRC_SOFTWARE_ARM_NOW: src_fire = 1'b1;
            csas_pkg::SRC_BUS: src_fire = cmd_bus;
            csas_pkg::SRC_TIMER: src_fire = timer_arm;
            csas_pkg::SRC_EXT_ARM: src_fire = ext_fire;
            csas_pkg::SRC_CHAN_TWO: src_fire = channel_two_arm_source;
            default: begin
                if (source_q >= csas_pkg::SRC_LINE_BASE && source_q <= csas_pkg::SRC_LINE_LAST
                    && int'(line_idx) < LINES) begin
                    src_fire = trig_lines[line_idx[3:0]];
                end
            end
        endcase
    end

    // Fixed category
    assign src_fixed = source_q == csas_pkg::SRC_HOLD || source_q == csas_pkg::SRC_SOFTWARE_ARM_NOW
                       || source_q == csas_pkg::SRC_TIMER
                       || source_q == csas_pkg::SRC_CHAN_TWO;

    // ************************************************************
    // Arm sequencer
    // ************************************************************
    csas_pkg::csas_state_t state_q;
    logic [15:0] ev_cnt_q;
    logic [15:0] us_cnt_q;
    logic [15:0] ops_q;
    logic [15:0] arms_q;
    logic arm_hit;
    logic arm_go;
    csas_tick_if tk ();

    csas_tick_gen u_tick (
        .ref_clk(ref_clk),
        .srst(srst),
        .tk(tk.gen)
    );

    // Restart divider when delay begins so the wait is whole microseconds
    assign tk.clear = state_q != csas_pkg::ST_DELAYING;

    // Event counting decides whether this source pulse arms
    always_comb begin
        arm_hit = 1'b0;
        if (src_fire) begin
            if (src_fixed || arm_event_count_q == 16'h0000) begin
                arm_hit = 1'b1;
            end else if (ev_cnt_q + 16'h0001 >= arm_event_count_q) begin
                arm_hit = 1'b1;
            end
        end
    end
    assign arm_go = arm_hit && (src_fixed || delay_q == 16'h0000);

    // Event counter, cleared on each initiation
    always_ff @(posedge ref_clk) begin
        if (srst || cmd_init || cmd_abort) begin
            ev_cnt_q <= 16'h0000;
        end else if (state_q == csas_pkg::ST_INITIATED && src_fire && !src_fixed) begin
            ev_cnt_q <= arm_hit ? 16'h0000 : ev_cnt_q + 16'h0001;
        end
    end

    // Microsecond delay counter
    always_ff @(posedge ref_clk) begin
        if (srst || cmd_init || cmd_abort) begin
            us_cnt_q <= 16'h0000;
        end else if (state_q != csas_pkg::ST_DELAYING) begin
            us_cnt_q <= 16'h0000;
        end else if (tk.tick) begin
            us_cnt_q <= us_cnt_q + 16'h0001;
        end
    end

    // Main state machine
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            state_q <= csas_pkg::ST_IDLE;
            ops_q <= 16'h0000;
            arms_q <= 16'h0000;
        end else if (cmd_abort) begin
            state_q <= csas_pkg::ST_IDLE;
        end else if (cmd_init) begin
            state_q <= csas_pkg::ST_INITIATED;
            ops_q <= 16'h0000;
            arms_q <= 16'h0000;
        end else begin
            case (state_q)
                csas_pkg::ST_IDLE: begin
                end
                csas_pkg::ST_INITIATED: begin
                    if (software_arm_now) begin
                        state_q <= csas_pkg::ST_ARMED;
                    end else if (arm_go) begin
                        state_q <= csas_pkg::ST_ARMED;
                    end else if (arm_hit) begin
                        state_q <= csas_pkg::ST_DELAYING;
                    end
                end
                csas_pkg::ST_DELAYING: begin
                    // Further source pulses are ignored here
                    if (software_arm_now) begin
                        state_q <= csas_pkg::ST_ARMED;
                    end else if (tk.tick && us_cnt_q + 16'h0001 >= delay_q) begin
                        state_q <= csas_pkg::ST_ARMED;
                    end
                end
                csas_pkg::ST_ARMED: begin
                    arms_q <= arms_q + 16'h0001;
                    state_q <= csas_pkg::ST_MEASURE;
                end
                csas_pkg::ST_MEASURE: begin
                    if (op_done) begin
                        ops_q <= ops_q + 16'h0001;
                        if (ops_q + 16'h0001 >= array_q) begin
                            state_q <= csas_pkg::ST_IDLE;
                        end else if (mode_once_q && array_q > 16'h0001) begin
                            state_q <= csas_pkg::ST_INITIATED;
                        end
                    end
                end
                default: begin
                    state_q <= csas_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // Operation start pulse and outputs
    logic op_start_q;
    logic armed_q;
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            op_start_q <= 1'b0;
            armed_q <= 1'b0;
        end else begin
            op_start_q <= (state_q == csas_pkg::ST_ARMED)
                          || (state_q == csas_pkg::ST_MEASURE && op_done
                              && ops_q + 16'h0001 < array_q
                              && !(mode_once_q && array_q > 16'h0001));
            armed_q <= state_q == csas_pkg::ST_ARMED;
        end
    end
    assign op_start = op_start_q;
    assign armed = armed_q;
    assign measuring = state_q != csas_pkg::ST_IDLE;
    assign external_arm_source = ext_fire;

    // ************************************************************
    // Read mux
    // ************************************************************
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            dat_q <= 32'h0000_0000;
        end else if (rd) begin
            case (wb_adr_i)
                csas_pkg::ADDR_CTRL: dat_q <= {30'h0000_0000, mode_once_q, slope_neg_q};
                csas_pkg::ADDR_SOURCE: dat_q <= {27'h000_0000, source_q};
                csas_pkg::ADDR_DELAY: dat_q <= {16'h0000, delay_q};
                csas_pkg::ADDR_ARM_EVENT_COUNT: dat_q <= {16'h0000, arm_event_count_q};
                csas_pkg::ADDR_LEVEL: dat_q <= {16'h0000, level_q};
                csas_pkg::ADDR_ARRAY: dat_q <= {16'h0000, array_q};
                csas_pkg::ADDR_STATUS: begin
                    dat_q <= {arms_q, 12'h000,
                              state_q == csas_pkg::ST_DELAYING,
                              state_q != csas_pkg::ST_IDLE,
                              state_q == csas_pkg::ST_ARMED,
                              state_q == csas_pkg::ST_INITIATED};
                end
                default: dat_q <= 32'h0000_0000;
            endcase
        end
    end
    assign wb_dat_o = dat_q;
endmodule : csas_seq

//--- verilog/csas_pkg.sv
package csas_pkg;
    // ************************************************************
    // Register map
    // ************************************************************
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_SOURCE = 8'h04;
    localparam logic [7:0] ADDR_DELAY = 8'h08;
    localparam logic [7:0] ADDR_ARM_EVENT_COUNT = 8'h0C;
    localparam logic [7:0] ADDR_LEVEL = 8'h10;
    localparam logic [7:0] ADDR_ARRAY = 8'h14;
    localparam logic [7:0] ADDR_STATUS = 8'h18;
    localparam logic [7:0] ADDR_CMD = 8'h1C;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int CTRL_SLOPE_NEG_BIT = 0;
    localparam int CTRL_MODE_ONCE_BIT = 1;
    localparam int CMD_INIT_BIT = 0;
    localparam int CMD_ABORT_BIT = 1;
    localparam int CMD_ARM_NOW_BIT = 2;
    localparam int CMD_BUS_TRIG_BIT = 3;
    localparam int STAT_ARMING_BIT = 0;
    localparam int STAT_ARMED_BIT = 1;
    localparam int STAT_MEAS_BIT = 2;
    localparam int STAT_DELAY_BIT = 3;

    // ************************************************************
    // Start arm sources
    // ************************************************************
    localparam logic [4:0] SRC_HOLD = 5'h00;
    localparam logic [4:0] SRC_SOFTWARE_ARM_NOW = 5'h01;
    localparam logic [4:0] SRC_BUS = 5'h02;
    localparam logic [4:0] SRC_TIMER = 5'h03;
    localparam logic [4:0] SRC_EXT_ARM = 5'h04;
    localparam logic [4:0] SRC_CHAN_TWO = 5'h05;
    localparam logic [4:0] SRC_LINE_BASE = 5'h08;
    localparam logic [4:0] SRC_LINE_LAST = 5'h17;

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [4:0] RST_SOURCE = SRC_SOFTWARE_ARM_NOW;
    localparam logic [15:0] RST_DELAY = 16'h0000;
    localparam logic [15:0] RST_ARM_EVENT_COUNT = 16'h0000;
    localparam logic [15:0] RST_LEVEL_MV = 16'h0578;
    localparam logic RST_SLOPE_NEG = 1'b0;
    localparam logic RST_MODE_ONCE = 1'b0;
    localparam logic [15:0] RST_ARRAY = 16'h0001;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int CLK_HZ = 25_000_000;
    localparam int TICK_NS = 1000;
    localparam int TICK_CYCLES = (CLK_HZ / 1_000_000) * TICK_NS / 1000;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_INITIATED,
        ST_DELAYING,
        ST_ARMED,
        ST_MEASURE
    } csas_state_t;
endpackage : csas_pkg

//--- verilog/csas_tick_if.sv
`timescale 1ns/1ns
interface csas_tick_if;
    logic clear;
    logic tick;
    modport gen (input clear, output tick);
    modport use_side (output clear, input tick);
endinterface : csas_tick_if

//--- verilog/csas_tick_gen.sv
`timescale 1ns/1ns
module csas_tick_gen #(
    parameter int CYCLES = csas_pkg::TICK_CYCLES
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // Tick carrier
    csas_tick_if.gen tk
);
    initial begin
        if (CYCLES < 1 || CYCLES > 65535) $error("csas_tick_gen: bad CYCLES");
    end

    logic [15:0] cnt_q;

    // Divider producing a one-cycle microsecond enable
    always_ff @(posedge ref_clk) begin
        if (srst || tk.clear || cnt_q == 16'(CYCLES - 1)) begin
            cnt_q <= 16'h0000;
        end else begin
            cnt_q <= cnt_q + 16'h0001;
        end
    end

    assign tk.tick = (cnt_q == 16'(CYCLES - 1)) && !tk.clear;
endmodule : csas_tick_gen

//--- verilog/csas_edge_cmp.sv
`timescale 1ns/1ns
module csas_edge_cmp (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // Sampled external arm level and threshold, signed millivolts
    input wire logic signed [15:0] sample_mv,
    input wire logic signed [15:0] level_mv,
    input wire logic slope_neg,
    // Crossing pulse
    output logic fire
);
    logic above_q;
    logic valid_q;
    logic above;

    assign above = sample_mv > level_mv;

    // Remember last side of the threshold
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            above_q <= 1'b0;
            valid_q <= 1'b0;
        end else begin
            above_q <= above;
            valid_q <= 1'b1;
        end
    end

    // Crossing in the selected direction
    always_comb begin
        fire = 1'b0;
        if (valid_q) begin
            fire = slope_neg ? (above_q && !above) : (!above_q && above);
        end
    end
endmodule : csas_edge_cmp

//--- sim/csas_properties.sv
`timescale 1ns/1ns
module csas_chk #(
    parameter int LINES = 16
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // Wishbone
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    // Sources
    input wire logic [LINES-1:0] trig_lines,
    input wire logic timer_arm,
    input wire logic channel_two_arm_source,
    input wire logic signed [15:0] ext_arm_mv,
    // Measurement side
    input wire logic op_done,
    input wire logic armed,
    input wire logic op_start,
    input wire logic measuring,
    input wire logic external_arm_source
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (srst);

    // ************************************************************
    // Bus and sequencer checks
    // ************************************************************
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    a_ack_follows_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not acknowledged next cycle");
    a_ack_has_req: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    a_dat_holds: assert property (!(wb_ack_o && !wb_we_i) |-> $stable(wb_dat_o))
        else $error("read data moved outside a read");
    a_arm_starts_op: assert property (armed |-> op_start)
        else $error("arm without operation start");
    a_arm_pulse: assert property (armed |=> !armed)
        else $error("arm pulse too long");
    a_arm_in_meas: assert property (armed |-> measuring)
        else $error("arm outside a measurement");
    a_op_cause: assert property (op_start && !armed |-> $past(op_done))
        else $error("operation start without cause");
    a_ext_single: assert property (external_arm_source |=> !external_arm_source)
        else $error("crossing pulse too long");
endmodule : csas_chk

//--- sim/csas_src_model.sv
`timescale 1ns/1ns
module csas_src_model #(
    parameter int LINES = 16
) (
    // Clock
    input wire logic ref_clk,
    // Bench commands
    input wire logic [4:0] fire_src,
    input wire logic fire_go,
    input wire logic signed [15:0] ext_goal,
    // Source outputs
    output logic [LINES-1:0] trig_lines,
    output logic timer_arm,
    output logic channel_two_arm_source,
    output logic signed [15:0] ext_arm_mv
);
    initial begin
        trig_lines = '0;
        timer_arm = 1'b0;
        channel_two_arm_source = 1'b0;
        ext_arm_mv = 16'sh0000;
    end

    // One-cycle pulse on the chosen source
    always @(posedge ref_clk) begin
        trig_lines <= '0;
        timer_arm <= fire_go && fire_src == csas_pkg::SRC_TIMER;
        channel_two_arm_source <= fire_go && fire_src == csas_pkg::SRC_CHAN_TWO;
        if (fire_go && fire_src >= csas_pkg::SRC_LINE_BASE) begin
            trig_lines[fire_src - csas_pkg::SRC_LINE_BASE] <= 1'b1;
        end
    end

    // External input ramps 100 mV a cycle, kept inside +/-20 V
    always @(posedge ref_clk) begin
        if (ext_arm_mv < ext_goal && ext_arm_mv < 16'sh4E20) begin
            ext_arm_mv <= ext_arm_mv + 16'sh0064;
        end else if (ext_arm_mv > ext_goal && ext_arm_mv > -16'sh4E20) begin
            ext_arm_mv <= ext_arm_mv - 16'sh0064;
        end
    end
endmodule : csas_src_model

//--- sim/test_counter_start_arm_sequencer.sv
`timescale 1ns/1ns
module test_counter_start_arm_sequencer;
    localparam int LINES = 16;
    localparam int LIMIT = 20000;
    logic ref_clk = 1'b0;
    logic srst = 1'b1;
    logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, op_done = 1'b0, fire_go = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [31:0] wb_dat_i = 32'h0000_0000;
    logic [3:0] wb_sel_i = 4'hF;
    logic [31:0] wb_dat_o, rdat;
    logic wb_ack_o, armed, op_start, measuring, external_arm_source;
    logic timer_arm, channel_two_arm_source;
    logic [LINES-1:0] trig_lines;
    logic signed [15:0] ext_arm_mv;
    logic signed [15:0] ext_goal = 16'sh0000;
    logic [4:0] fire_src = 5'h00;
    int miscompares = 0, n_tests = 0, cyc_n = 0, n_arm = 0, n_op = 0, n_ext = 0, t_arm = 0;
    int a, o, e, t0;

    always #20 ref_clk = ~ref_clk;

    csas_seq #(.LINES(LINES)) DUT (.ref_clk(ref_clk), .srst(srst), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
        .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .trig_lines(trig_lines),
        .timer_arm(timer_arm), .channel_two_arm_source(channel_two_arm_source),
        .ext_arm_mv(ext_arm_mv), .op_done(op_done), .armed(armed), .op_start(op_start),
        .measuring(measuring), .external_arm_source(external_arm_source));
    csas_src_model #(.LINES(LINES)) u_src (.ref_clk(ref_clk), .fire_src(fire_src),
        .fire_go(fire_go), .ext_goal(ext_goal), .trig_lines(trig_lines), .timer_arm(timer_arm),
        .channel_two_arm_source(channel_two_arm_source), .ext_arm_mv(ext_arm_mv));

    // Event counters and timeout
    always @(posedge ref_clk) begin
        cyc_n++;
        if (armed === 1'b1) begin
            n_arm++;
            t_arm = cyc_n;
        end
        if (op_start === 1'b1) n_op++;
        if (external_arm_source === 1'b1) n_ext++;
        if (cyc_n == LIMIT) begin
            miscompares++;
            end_of_test();
        end
    end

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : end_of_test

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // Classic single Wishbone cycle
    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] d);
        @(posedge ref_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= d;
        do begin
            @(posedge ref_clk);
        end while (wb_ack_o !== 1'b1);
        rdat = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask : wb

    task automatic rd(input logic [7:0] adr, input logic [31:0] exp);
        wb(1'b0, adr, 32'h0000_0000);
        chk(rdat, exp);
    endtask : rd

    task automatic idle(input int n);
        repeat (n) @(posedge ref_clk);
    endtask : idle

    task automatic fire(input logic [4:0] s);
        @(posedge ref_clk);
        fire_src <= s;
        fire_go <= 1'b1;
        @(posedge ref_clk);
        fire_go <= 1'b0;
    endtask : fire

    task automatic done_op();
        @(posedge ref_clk);
        op_done <= 1'b1;
        @(posedge ref_clk);
        op_done <= 1'b0;
    endtask : done_op

    // ************************************************************
    // Test sequence
    // ************************************************************
    initial begin
        idle(2);
        srst <= 1'b0;
        rd(csas_pkg::ADDR_SOURCE, 32'h0000_0001);
        rd(csas_pkg::ADDR_DELAY, 32'h0000_0000);
        rd(csas_pkg::ADDR_ARM_EVENT_COUNT, 32'h0000_0000);
        rd(csas_pkg::ADDR_LEVEL, 32'h0000_0578);
        rd(csas_pkg::ADDR_CTRL, 32'h0000_0000);
        rd(8'h20, 32'h0000_0000);
        // Pass-through on the software_arm_now source
        a = n_arm;
        wb(1'b1, csas_pkg::ADDR_CMD, 32'h0000_0001);
        idle(6);
        chk(n_arm - a, 1);
        chk({31'd0, measuring}, 1);
        rd(csas_pkg::ADDR_STATUS, 32'h0001_0004);
        done_op();
        idle(2);
        chk({31'd0, measuring}, 0);
        // Delay and count clear each other
        wb(1'b1, csas_pkg::ADDR_DELAY, 32'h0000_0005);
        wb(1'b1, csas_pkg::ADDR_ARM_EVENT_COUNT, 32'h0000_0003);
        rd(csas_pkg::ADDR_DELAY, 32'h0000_0000);
        wb(1'b1, csas_pkg::ADDR_DELAY, 32'h0000_0002);
        rd(csas_pkg::ADDR_ARM_EVENT_COUNT, 32'h0000_0000);
        // Count of three on line 0, abort in mid-count
        wb(1'b1, csas_pkg::ADDR_ARM_EVENT_COUNT, 32'h0000_0003);
        wb(1'b1, csas_pkg::ADDR_SOURCE, 32'h0000_0008);
        a = n_arm;
        wb(1'b1, csas_pkg::ADDR_CMD, 32'h0000_0001);
        fire(5'h08);
        fire(5'h08);
        wb(1'b1, csas_pkg::ADDR_CMD, 32'h0000_0002);
        wb(1'b1, csas_pkg::ADDR_CMD, 32'h0000_0001);
        fire(5'h08);
        fire(5'h08);
        idle(4);
        chk(n_arm - a, 0);
        fire(5'h08);
        idle(4);
        chk(n_arm - a, 1);
        done_op();
        // Two microsecond delay on line 1, second pulse mid-delay
        wb(1'b1, csas_pkg::ADDR_DELAY, 32'h0000_0002);
        wb(1'b1, csas_pkg::ADDR_SOURCE, 32'h0000_0009);
        wb(1'b1, csas_pkg::ADDR_CMD, 32'h0000_0001);
        a = n_arm;
        fire(5'h09);
        t0 = cyc_n;
        rd(csas_pkg::ADDR_STATUS, 32'h0000_000C);
        idle(20);
        fire(5'h09);
        idle(50);
        chk(n_arm - a, 1);
        chk({31'd0, (t_arm - t0 >= 49) && (t_arm - t0 <= 54)}, 1);
        done_op();
        // Fixed sources ignore a programmed count
        wb(1'b1, csas_pkg::ADDR_ARM_EVENT_COUNT, 32'h0000_0003);
        for (int k = 0; k < 2; k++) begin
            wb(1'b1, csas_pkg::ADDR_SOURCE, k ? 32'h0000_0005 : 32'h0000_0003);
            wb(1'b1, csas_pkg::ADDR_CMD, 32'h0000_0001);
            a = n_arm;
            fire(k ? csas_pkg::SRC_CHAN_TWO : csas_pkg::SRC_TIMER);
            idle(4);
            chk(n_arm - a, 1);
            done_op();
        end
        // Hold never arms; software arm-now does
        wb(1'b1, csas_pkg::ADDR_SOURCE, 32'h0000_0000);
        wb(1'b1, csas_pkg::ADDR_CMD, 32'h0000_0001);
        a = n_arm;
        idle(10);
        chk(n_arm - a, 0);
        wb(1'b1, csas_pkg::ADDR_CMD, 32'h0000_0004);
        idle(4);
        chk(n_arm - a, 1);
        done_op();
        // External arm, rising then falling crossing of 1000 mV
        wb(1'b1, csas_pkg::ADDR_ARM_EVENT_COUNT, 32'h0000_0000);
        wb(1'b1, csas_pkg::ADDR_LEVEL, 32'h0000_03E8);
        wb(1'b1, csas_pkg::ADDR_SOURCE, 32'h0000_0004);
        for (int k = 0; k < 2; k++) begin
            wb(1'b1, csas_pkg::ADDR_CTRL, k);
            wb(1'b1, csas_pkg::ADDR_CMD, 32'h0000_0001);
            a = n_arm;
            e = n_ext;
            ext_goal <= k ? -16'sh07D0 : 16'sh07D0;
            idle(50);
            chk(n_ext - e, 1);
            chk(n_arm - a, 1);
            done_op();
        end
        // Array of three: once mode, then all mode
        wb(1'b1, csas_pkg::ADDR_ARRAY, 32'h0000_0003);
        wb(1'b1, csas_pkg::ADDR_SOURCE, 32'h0000_0002);
        for (int m = 1; m >= 0; m--) begin
            wb(1'b1, csas_pkg::ADDR_CTRL, m ? 32'h0000_0002 : 32'h0000_0000);
            wb(1'b1, csas_pkg::ADDR_CMD, 32'h0000_0001);
            a = n_arm;
            o = n_op;
            for (int i = 0; i < 3; i++) begin
                if (m == 1 || i == 0) wb(1'b1, csas_pkg::ADDR_CMD, 32'h0000_0008);
                idle(4);
                chk(n_op - o, i + 1);
                done_op();
                idle(3);
            end
            chk(n_arm - a, m ? 3 : 1);
            chk({31'd0, measuring}, 0);
        end
        end_of_test();
    end
endmodule : test_counter_start_arm_sequencer

bind csas_seq csas_chk #(.LINES(LINES)) u_chk (.ref_clk(ref_clk), .srst(srst),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .trig_lines(trig_lines), .timer_arm(timer_arm),
    .channel_two_arm_source(channel_two_arm_source), .ext_arm_mv(ext_arm_mv),
    .op_done(op_done), .armed(armed), .op_start(op_start), .measuring(measuring),
    .external_arm_source(external_arm_source));
